// File: logic/serial_port_pkg.sv
// constants, register map and carrier types of the serial master port
package serial_port_pkg;

    // register byte addresses
    localparam logic [31:0] ADDR_RX_BYTE     = 32'h5001_5000;
    localparam logic [31:0] ADDR_TX_BYTE     = 32'h5001_5004;
    localparam logic [31:0] ADDR_CONTROL     = 32'h5001_5008;
    localparam logic [31:0] ADDR_FIFO_STATUS = 32'h5001_500C;
    localparam logic [31:0] ADDR_IRQ_STATUS  = 32'h5001_5010;
    localparam logic [31:0] ADDR_IRQ_ENABLE  = 32'h5001_5014;
    localparam logic [31:0] ADDR_IRQ_CLEAR   = 32'h5001_5018;

    // serial_control field positions
    localparam int CTL_FIFO_CLR_BIT = 24;
    localparam int CTL_LOOPBACK_BIT = 16;
    localparam int CTL_TRANSFER_IRQ_COUNT_LSB     = 8;
    localparam int CTL_DIV_EXT_LSB  = 6;
    localparam int CTL_CPOL_BIT     = 5;
    localparam int CTL_CPHA_BIT     = 4;
    localparam int CTL_DIV_STD_LSB  = 2;
    localparam int CTL_ENABLE_STATE_BIT  = 1;
    localparam int CTL_ENABLE_REQUEST_BIT  = 0;

    // serial_fifo_status field positions
    localparam int ST_TX_LEVEL_LSB = 16;
    localparam int ST_RX_LEVEL_LSB = 8;
    localparam int ST_TX_FULL_BIT  = 6;
    localparam int ST_TX_EMPTY_BIT = 5;
    localparam int ST_RX_FULL_BIT  = 4;
    localparam int ST_RX_EMPTY_BIT = 3;
    localparam int ST_TX_OVF_BIT   = 2;
    localparam int ST_RX_UNF_BIT   = 1;
    localparam int ST_XFER_BIT     = 0;

    // interrupt status, enable and clear share this layout
    localparam int IRQ_TX_OVF_BIT = 2;
    localparam int IRQ_RX_UNF_BIT = 1;
    localparam int IRQ_XFER_BIT   = 0;

    // reset values
    localparam logic [2:0] IRQ_ENABLE_RST = 3'h0;
    localparam logic [7:0] BYTE_RST       = 8'h00;

    // geometry
    localparam int BYTE_BITS     = 8;
    localparam int FIFO_DEPTH    = 16;
    localparam int LEVEL_BITS    = 5;
    localparam int EDGES_PER_XFER = 2 * BYTE_BITS;

    // half serial clock period minus one, indexed by {extended, standard}
    localparam logic [11:0] DIV_HALF_TBL [0:15] = '{
        12'h000, 12'h001, 12'h003, 12'h00F,
        12'h01F, 12'h007, 12'h03F, 12'h07F,
        12'h0FF, 12'h1FF, 12'h3FF, 12'h7FF,
        12'h7FF, 12'h7FF, 12'h7FF, 12'h7FF
    };

    typedef struct packed {
        logic       loopback_select;
        logic [1:0] transfer_irq_count;
        logic [1:0] clock_div_extended;
        logic       cpol;
        logic       cpha;
        logic [1:0] clock_div_standard;
        logic       enable_request;
    } control_s;

    localparam control_s CONTROL_RST = '0;

    typedef struct packed {
        logic       tx_overflow_irq;
        logic       rx_underflow_irq;
        logic       transfers_reached_irq;
    } irq_flags_s;

    typedef enum logic [1:0] {
        LINK_IDLE   = 2'b00,
        LINK_SHIFT  = 2'b01,
        LINK_FINISH = 2'b11
    } link_state_e;

endpackage

// File: logic/spi_master_fifo_port.sv
// serial master with byte FIFOs behind an APB register bank
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
module spi_master_fifo_port
    import serial_port_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // serial link
    output logic             sclk,
    output logic             mosi,
    output logic             cs_n,
    input  wire logic        miso,
    // interrupt request
    output logic             irq
);

    localparam int PTR_BITS = $clog2(DEPTH);

    // queue 0 is transmit, queue 1 is receive
    logic [1:0]              q_push;
    logic [1:0]              q_pop;
    logic [BYTE_BITS-1:0]    q_wdata [2];
    logic [BYTE_BITS-1:0]    q_head  [2];
    logic [LEVEL_BITS-1:0]   q_level [2];
    logic [1:0]              q_full;
    logic [1:0]              q_empty;

    control_s                control_reg;
    logic                    enable_state_reg;
    logic                    fifo_clear_reg;
    logic [2:0]              irq_clear_reg;
    logic [2:0]              irq_enable_reg;
    irq_flags_s              flags_reg;
    logic [BYTE_BITS-1:0]    last_rx_reg;
    logic                    rx_pop_ok_reg;
    logic                    pready_reg;
    logic [31:0]             prdata_reg;
    logic                    pslverr_reg;
    logic                    irq_reg;

    link_state_e             state_reg;
    logic [11:0]             half_cnt_reg;
    logic [4:0]              edge_cnt_reg;
    logic [BYTE_BITS-1:0]    tx_sh_reg;
    logic [BYTE_BITS-1:0]    rx_sh_reg;
    logic                    sclk_reg;
    logic                    mosi_reg;
    logic                    cs_n_reg;
    logic [1:0]              xfer_cnt_reg;

    logic                    bus_setup;
    logic                    bus_done;
    logic                    wr_done;
    logic                    rd_done;
    logic                    addr_hit;
    logic [11:0]             half_load;
    logic                    half_end;
    logic                    leading;
    logic                    sample_edge;
    logic                    change_edge;
    logic                    rx_in;
    logic                    xfer_done;
    logic                    xfer_event;
    logic                    start_xfer;

    // ---------------- byte queues ----------------
    genvar q;
    generate
        for (q = 0; q < 2; q++) begin : g_queue
            logic [BYTE_BITS-1:0]  mem [DEPTH];
            logic [PTR_BITS-1:0]   wptr_reg;
            logic [PTR_BITS-1:0]   rptr_reg;
            logic [LEVEL_BITS-1:0] level_reg;
            logic                  do_push;
            logic                  do_pop;

            assign do_push = q_push[q] && (level_reg != LEVEL_BITS'(DEPTH));
            assign do_pop  = q_pop[q] && (level_reg != '0);

            always_ff @(posedge clk_sys) begin
                if (do_push) begin
                    mem[wptr_reg] <= q_wdata[q];
                end
            end

            always_ff @(posedge clk_sys) begin
                if (!nrst || fifo_clear_reg) begin
                    wptr_reg  <= '0;
                    rptr_reg  <= '0;
                    level_reg <= '0;
                end else begin
                    if (do_push) begin
                        wptr_reg <= wptr_reg + 1'b1;
                    end
                    if (do_pop) begin
                        rptr_reg <= rptr_reg + 1'b1;
                    end
                    if (do_push && !do_pop) begin
                        level_reg <= level_reg + 1'b1;
                    end else if (do_pop && !do_push) begin
                        level_reg <= level_reg - 1'b1;
                    end
                end
            end

            assign q_head[q]  = mem[rptr_reg];
            assign q_level[q] = level_reg;
            assign q_full[q]  = (level_reg == LEVEL_BITS'(DEPTH));
            assign q_empty[q] = (level_reg == '0);
        end
    endgenerate

    // ---------------- apb slave ----------------
    assign bus_setup = psel && penable && !pready_reg;
    assign bus_done  = psel && penable && pready_reg;
    assign wr_done   = bus_done && pwrite;
    assign rd_done   = bus_done && !pwrite;

    always_comb begin
        case (paddr)
            ADDR_RX_BYTE, ADDR_TX_BYTE, ADDR_CONTROL, ADDR_FIFO_STATUS,
            ADDR_IRQ_STATUS, ADDR_IRQ_ENABLE, ADDR_IRQ_CLEAR: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // answer one cycle into the access phase, data prepared at that edge
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pready_reg     <= 1'b0;
            pslverr_reg    <= 1'b0;
            prdata_reg     <= '0;
            rx_pop_ok_reg  <= 1'b0;
        end else begin
            pready_reg     <= bus_setup;
            pslverr_reg    <= bus_setup && !addr_hit;
            rx_pop_ok_reg  <= !q_empty[1];
            prdata_reg     <= '0;
            if (bus_setup && !pwrite) begin
                case (paddr)
                    ADDR_RX_BYTE: begin
                        prdata_reg[7:0] <= q_empty[1] ? last_rx_reg : q_head[1];
                    end
                    ADDR_CONTROL: begin
                        prdata_reg[CTL_LOOPBACK_BIT]                <= control_reg.loopback_select;
                        prdata_reg[CTL_TRANSFER_IRQ_COUNT_LSB +: 2]               <= control_reg.transfer_irq_count;
                        prdata_reg[CTL_DIV_EXT_LSB +: 2]            <= control_reg.clock_div_extended;
                        prdata_reg[CTL_CPOL_BIT]                    <= control_reg.cpol;
                        prdata_reg[CTL_CPHA_BIT]                    <= control_reg.cpha;
                        prdata_reg[CTL_DIV_STD_LSB +: 2]            <= control_reg.clock_div_standard;
                        prdata_reg[CTL_ENABLE_STATE_BIT]                 <= enable_state_reg;
                        prdata_reg[CTL_ENABLE_REQUEST_BIT]                 <= control_reg.enable_request;
                    end
                    ADDR_FIFO_STATUS: begin
                        prdata_reg[ST_TX_LEVEL_LSB +: LEVEL_BITS] <= q_level[0];
                        prdata_reg[ST_RX_LEVEL_LSB +: LEVEL_BITS] <= q_level[1];
                        prdata_reg[ST_TX_FULL_BIT]  <= q_full[0];
                        prdata_reg[ST_TX_EMPTY_BIT] <= q_empty[0];
                        prdata_reg[ST_RX_FULL_BIT]  <= q_full[1];
                        prdata_reg[ST_RX_EMPTY_BIT] <= q_empty[1];
                        prdata_reg[ST_TX_OVF_BIT]   <= flags_reg.tx_overflow_irq;
                        prdata_reg[ST_RX_UNF_BIT]   <= flags_reg.rx_underflow_irq;
                        prdata_reg[ST_XFER_BIT]     <= flags_reg.transfers_reached_irq;
                    end
                    ADDR_IRQ_STATUS: begin
                        prdata_reg[2:0] <= flags_reg & irq_enable_reg;
                    end
                    ADDR_IRQ_ENABLE: begin
                        prdata_reg[2:0] <= irq_enable_reg;
                    end
                    default: begin
                        prdata_reg <= '0;
                    end
                endcase
            end
        end
    end

    // software-written control
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            control_reg    <= CONTROL_RST;
            irq_enable_reg <= IRQ_ENABLE_RST;
            fifo_clear_reg <= 1'b0;
            irq_clear_reg  <= '0;
        end else begin
            fifo_clear_reg <= 1'b0;
            irq_clear_reg  <= '0;
            if (wr_done && paddr == ADDR_CONTROL) begin
                control_reg.loopback_select    <= pwdata[CTL_LOOPBACK_BIT];
                control_reg.transfer_irq_count <= pwdata[CTL_TRANSFER_IRQ_COUNT_LSB +: 2];
                control_reg.clock_div_extended <= pwdata[CTL_DIV_EXT_LSB +: 2];
                control_reg.cpol               <= pwdata[CTL_CPOL_BIT];
                control_reg.cpha               <= pwdata[CTL_CPHA_BIT];
                control_reg.clock_div_standard <= pwdata[CTL_DIV_STD_LSB +: 2];
                control_reg.enable_request     <= pwdata[CTL_ENABLE_REQUEST_BIT];
                fifo_clear_reg                 <= pwdata[CTL_FIFO_CLR_BIT];
            end
            if (wr_done && paddr == ADDR_IRQ_ENABLE) begin
                irq_enable_reg <= pwdata[2:0];
            end
            if (wr_done && paddr == ADDR_IRQ_CLEAR) begin
                irq_clear_reg <= pwdata[2:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            enable_state_reg <= 1'b0;
        end else begin
            enable_state_reg <= control_reg.enable_request;
        end
    end

    // queue accesses from the bus and the shifter
    assign q_push[0]  = wr_done && (paddr == ADDR_TX_BYTE);
    assign q_wdata[0] = pwdata[7:0];
    assign q_pop[1]   = rd_done && (paddr == ADDR_RX_BYTE) && rx_pop_ok_reg;
    assign q_pop[0]   = start_xfer;
    assign q_push[1]  = xfer_done;
    assign q_wdata[1] = rx_sh_reg;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            last_rx_reg <= BYTE_RST;
        end else if (q_pop[1]) begin
            last_rx_reg <= q_head[1];
        end
    end

    // sticky flags; a set in the clear cycle wins
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            flags_reg <= '0;
        end else begin
            // same full test that drops the push, so a landed byte never flags
            if (wr_done && paddr == ADDR_TX_BYTE && q_full[0]) begin
                flags_reg.tx_overflow_irq <= 1'b1;
            end else if (irq_clear_reg[IRQ_TX_OVF_BIT]) begin
                flags_reg.tx_overflow_irq <= 1'b0;
            end
            if (rd_done && paddr == ADDR_RX_BYTE && !rx_pop_ok_reg) begin
                flags_reg.rx_underflow_irq <= 1'b1;
            end else if (irq_clear_reg[IRQ_RX_UNF_BIT]) begin
                flags_reg.rx_underflow_irq <= 1'b0;
            end
            if (xfer_event) begin
                flags_reg.transfers_reached_irq <= 1'b1;
            end else if (irq_clear_reg[IRQ_XFER_BIT]) begin
                flags_reg.transfers_reached_irq <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(flags_reg & irq_enable_reg);
        end
    end

    // ---------------- transfer counter ----------------
    assign xfer_event = xfer_done && (xfer_cnt_reg == control_reg.transfer_irq_count);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            xfer_cnt_reg <= '0;
        end else if (xfer_done) begin
            xfer_cnt_reg <= xfer_event ? 2'h0 : xfer_cnt_reg + 1'b1;
        end
    end

    // ---------------- serial shifter ----------------
    assign half_load   = DIV_HALF_TBL[{control_reg.clock_div_extended,
                                       control_reg.clock_div_standard}];
    assign half_end    = (half_cnt_reg == '0);
    assign leading     = !edge_cnt_reg[0];
    assign sample_edge = half_end && (leading ^ control_reg.cpha);
    assign change_edge = half_end && !(leading ^ control_reg.cpha)
                         && (edge_cnt_reg != 5'(EDGES_PER_XFER - 1));
    assign rx_in       = control_reg.loopback_select ? mosi_reg : miso;
    assign start_xfer  = (state_reg == LINK_IDLE) && enable_state_reg && !q_empty[0];
    assign xfer_done   = (state_reg == LINK_FINISH);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_reg    <= LINK_IDLE;
            half_cnt_reg <= '0;
            edge_cnt_reg <= '0;
            tx_sh_reg    <= '0;
            rx_sh_reg    <= '0;
            sclk_reg     <= 1'b0;
            mosi_reg     <= 1'b0;
            cs_n_reg     <= 1'b1;
        end else begin
            case (state_reg)
                LINK_IDLE: begin
                    sclk_reg <= control_reg.cpol;
                    cs_n_reg <= 1'b1;
                    if (start_xfer) begin
                        state_reg    <= LINK_SHIFT;
                        half_cnt_reg <= half_load;
                        edge_cnt_reg <= '0;
                        cs_n_reg     <= 1'b0;
                        if (control_reg.cpha) begin
                            tx_sh_reg <= q_head[0];
                        end else begin
                            mosi_reg  <= q_head[0][7];
                            tx_sh_reg <= {q_head[0][6:0], 1'b0};
                        end
                    end
                end
                LINK_SHIFT: begin
                    if (half_end) begin
                        half_cnt_reg <= half_load;
                        sclk_reg     <= !sclk_reg;
                        edge_cnt_reg <= edge_cnt_reg + 1'b1;
                        if (edge_cnt_reg == 5'(EDGES_PER_XFER - 1)) begin
                            state_reg <= LINK_FINISH;
                        end
                    end else begin
                        half_cnt_reg <= half_cnt_reg - 1'b1;
                    end
                    if (sample_edge) begin
                        rx_sh_reg <= {rx_sh_reg[6:0], rx_in};
                    end
                    if (change_edge) begin
                        mosi_reg  <= tx_sh_reg[7];
                        tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
                    end
                end
                LINK_FINISH: begin
                    state_reg <= LINK_IDLE;
                    cs_n_reg  <= 1'b1;
                end
                default: begin
                    state_reg <= LINK_IDLE;
                end
            endcase
        end
    end

    assign pready  = pready_reg;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;
    assign sclk    = sclk_reg;
    assign mosi    = mosi_reg;
    assign cs_n    = cs_n_reg;
    assign irq     = irq_reg;

endmodule

// File: tb/serial_port_checker.sv
// concurrent checks on the ports of the serial master port
`timescale 1ns/100ps
module serial_port_checker
    import serial_port_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        nrst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // serial link and interrupt
    input wire logic        sclk,
    input wire logic        mosi,
    input wire logic        cs_n,
    input wire logic        miso,
    input wire logic        irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic [4:0] edges;
    logic       sclk_q;
    logic       idle_lvl;
    wire        rd = pready && !pwrite;
    // sclk toggles seen inside the current frame
    always_ff @(posedge clk_sys) begin
        sclk_q <= sclk;
        edges  <= (!nrst || cs_n) ? 5'h00 : edges + 5'(sclk != sclk_q);
    end
    always_ff @(posedge clk_sys) begin
        if (cs_n) begin
            idle_lvl <= sclk;
        end
    end
    a_ready_follows: assert property ($rose(penable) && psel |=> pready)
        else $error("pready late");
    a_unmapped_err: assert property (pready && paddr > ADDR_IRQ_CLEAR |-> pslverr && prdata == 0)
        else $error("unmapped access not refused");
    a_wo_zero: assert property (rd && paddr == ADDR_IRQ_CLEAR |-> prdata == 0)
        else $error("write-only register read nonzero");
    a_clr_bit_zero: assert property (rd && paddr == ADDR_CONTROL |-> !prdata[24])
        else $error("fifo clear bit stuck");
    a_empty_flags: assert property (rd && paddr == ADDR_FIFO_STATUS |->
        prdata[5] == (prdata[20:16] == 0) && prdata[3] == (prdata[12:8] == 0))
        else $error("empty flag disagrees with level");
    a_edge_count: assert property ($rose(cs_n) |-> edges == 5'h10)
        else $error("wrong sclk edge count");
    a_idle_level: assert property ($rose(cs_n) |-> sclk == idle_lvl)
        else $error("sclk not back at idle level");
    a_irq_or: assert property (rd && paddr == ADDR_IRQ_STATUS && prdata[2:0] != 0 |->
        ##[0:2] irq)
        else $error("irq missing");
    c_frame: cover property ($rose(cs_n));
    c_refused: cover property (pready && pslverr);
    c_irq: cover property ($rose(irq));
endmodule
bind spi_master_fifo_port serial_port_checker i_chk (.clk_sys, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .sclk, .mosi, .cs_n, .miso, .irq);

// File: tb/serial_slave_model.sv
// behavioural serial slave answering one byte per frame
`timescale 1ns/100ps
module serial_slave_model (
    // serial link
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       mosi,
    output logic            miso,
    // mode and data
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic [7:0] reply,
    output logic [7:0]      got
);
    logic [7:0] sr;
    initial begin
        miso = 1'b1;
        got = 8'h00;
        sr = 8'h00;
    end
    // deselected line shows no stale bit
    always @(posedge cs_n) miso = ~miso;
    always @(negedge cs_n) begin
        sr = reply;
        if (!cpha) miso = reply[7];
    end
    always @(sclk) begin
        if (!cs_n && ((sclk != cpol) != cpha)) begin
            got = {got[6:0], mosi};
        end else if (!cs_n && cpha) begin
            miso = sr[7];
            sr = {sr[6:0], 1'b0};
        end else if (!cs_n) begin
            sr = {sr[6:0], 1'b0};
            miso = sr[7];
        end
    end
endmodule

// File: tb/spi_master_fifo_port_bench.sv
// self-checking bench for the serial master port
`timescale 1ns/100ps
module spi_master_fifo_port_bench import serial_port_pkg::*;;
    logic        clk_sys, nrst, psel, penable, pwrite, pready, pslverr;
    logic        sclk, mosi, cs_n, miso, irq, cpol, cpha, rerr;
    logic [31:0] paddr, pwdata, prdata, rdat;
    logic [7:0]  reply, got;
    int          fails, total_checks, cycles, h;
    logic [31:0] mode_tbl [5] = '{32'h0, 32'h24, 32'h18, 32'h3C, 32'h1_0044};
    int          half_tbl [5] = '{1, 2, 4, 16, 8};
    spi_master_fifo_port i_dut (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .sclk, .mosi, .cs_n, .miso, .irq);
    serial_slave_model i_slave (.sclk, .cs_n, .mosi, .miso, .cpol, .cpha, .reply, .got);
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        chk(name, rdat, exp);
    endtask
    // waits out one frame and measures the sclk half period
    task automatic frame(output int hp);
        logic s;
        int   n;
        n = 0;
        hp = 0;
        while (cs_n !== 1'b0 && n < 200) @(posedge clk_sys) n++;
        if (cs_n !== 1'b0) fails++;
        s = sclk;
        while (sclk === s && n < 400) @(posedge clk_sys) n++;
        s = sclk;
        while (sclk === s && hp < 400) @(posedge clk_sys) hp++;
        while (cs_n !== 1'b1 && n < 900) @(posedge clk_sys) n++;
        if (n >= 900) fails++;
        @(posedge clk_sys);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        cycles = 0;
        forever @(posedge clk_sys) if (++cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        {nrst, psel, penable, pwrite, cpol, cpha} = 6'h00;
        {paddr, pwdata, reply} = 72'h0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rd(ADDR_FIFO_STATUS, 32'h28, "status");
        rd(ADDR_CONTROL, 32'h0, "control");
        rd(ADDR_IRQ_ENABLE, 32'h0, "irq enable");
        apb(1'b0, 32'h5001_5020, 32'h0);
        chk("slverr", 32'(rerr), 32'h1);
        for (int i = 0; i <= FIFO_DEPTH; i++) apb(1'b1, ADDR_TX_BYTE, 32'h80 + i);
        chk("cs_n", 32'(cs_n), 32'h1);
        rd(ADDR_FIFO_STATUS, 32'h0010_004C, "full");
        apb(1'b1, ADDR_CONTROL, 32'h0100_0000);
        rd(ADDR_FIFO_STATUS, 32'h2C, "cleared");
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h7);
        rd(ADDR_IRQ_STATUS, 32'h4, "ovf irq");
        chk("irq", 32'(irq), 32'h1);
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h4);
        rd(ADDR_IRQ_CLEAR, 32'h0, "clear reg");
        rd(ADDR_IRQ_STATUS, 32'h0, "irq cleared");
        rd(ADDR_RX_BYTE, 32'h0, "empty rx");
        rd(ADDR_FIFO_STATUS, 32'h2A, "underflow");
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h2);
        for (int m = 0; m < 5; m++) begin
            cpol <= mode_tbl[m][CTL_CPOL_BIT];
            cpha <= mode_tbl[m][CTL_CPHA_BIT];
            reply <= 8'hC3 ^ 8'(m);
            apb(1'b1, ADDR_CONTROL, mode_tbl[m]);
            apb(1'b1, ADDR_TX_BYTE, 32'h96 + m);
            chk("idle sclk", 32'(sclk), 32'(cpol));
            apb(1'b1, ADDR_CONTROL, mode_tbl[m] | 32'h1);
            frame(h);
            chk("half period", 32'(h), 32'(half_tbl[m]));
            chk("slave byte", 32'(got), 32'h96 + m);
            rd(ADDR_RX_BYTE, m == 4 ? 32'h96 + m : 32'hC3 ^ m, "rx byte");
        end
        rd(ADDR_CONTROL, 32'h1_0047, "enabled");
        apb(1'b1, ADDR_CONTROL, 32'h101);
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h1);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, ADDR_TX_BYTE, 32'h5A);
            frame(h);
            rd(ADDR_IRQ_STATUS, 32'(k), "count irq");
        end
        tally_and_finish();
    end
endmodule
